// File: core/scs_ctrl.sv
// serial command front end with settings store, restore and counters
`timescale 1ns/1ps

// Overview of operation
// (RL1) store command writes every setting and parameter to nonvolatile memory
// (RL2) at power-up read saved image, check it, load it if good
// (RL3) failed image check loads factory defaults instead
// (RL4) preset command loads defaults and selects continuous attenuation mode
// (RL5) hour counter increments once per full hour of operation
// (RL6) partial hour is lost at power-off; stored hours unchanged
// (RL7) power-up counter increments once on every power-up
// (RL8) version reported as text Rx.x mm/dd/yy
// (RL9) only one serial port is active; the other is ignored
// (RL10) active port is the one receiving the first byte
// (RL11) port choice stays latched until power-off
// (RL12) link runs 115200 baud, 8 data bits, no parity, 1 stop
// (RL13) usb bridge gives the same byte stream as the direct port
// (RL14) only the first command of a line is processed
// (RL15) host sends lines of at most 64 characters
// (RL16) two command slots; host must not queue a third
// (RL17) host should use operation-complete query between rapid commands
// (RL18) command set follows scpi 1999.0 syntax, subset only
// (RL19) line feed ends a line and hands it to execution
// (RL20) command arriving with both slots full is dropped and logged
module scs_ctrl
  import scs_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        uart_rx,
  input  wire logic                        usb_rx,
  input  wire logic [2:0]                  cmd_code,
  input  wire logic                        exec_done,
  input  wire logic                        nvm_ack,
  input  wire logic [PAR_W-1:0]            nvm_rdata,
  input  wire logic                        ver_take,
  output logic                             line_valid,
  output logic [7:0]                       line_char,
  output logic [5:0]                       line_len,
  output logic                             nvm_req,
  output logic                             nvm_we,
  output logic [3:0]                       nvm_addr,
  output logic [PAR_W-1:0]                 nvm_wdata,
  output logic [NPAR*PAR_W-1:0]            params,
  output scs_pkg::scs_mode_t               mode,
  output scs_pkg::scs_port_t               active_port,
  output logic [HOUR_W-1:0]                hours,
  output logic [PWR_W-1:0]                 power_ups,
  output logic [7:0]                       ver_char,
  output logic                             ver_last,
  output logic                             err_valid,
  output logic [7:0]                       err_code,
  output logic                             restore_ok
);
  // ---------------- receivers, one per port ----------------
  logic [1:0]       rx_pin;
  logic [1:0]       rx_stb;
  logic [7:0]       rx_byte [2];
  assign rx_pin = {usb_rx, uart_rx};

  // identical 8N1 receivers; the bridge makes usb look like uart [RL13]
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rx
      logic [15:0] cnt_r;
      logic [3:0]  bit_r;
      logic [7:0]  sh_r;
      logic        busy_r;
      logic        stb_r;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_r  <= 16'h0000;
          bit_r  <= 4'h0;
          sh_r   <= 8'h00;
          busy_r <= 1'b0;
          stb_r  <= 1'b0;
        end else begin
          stb_r <= 1'b0;
          if (!busy_r) begin
            if (!rx_pin[g]) begin // start edge [RL12]
              busy_r <= 1'b1;
              cnt_r  <= 16'(HALF_CYC);
              bit_r  <= 4'h0;
            end
          end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            cnt_r <= 16'(BIT_CYC - 1);
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h0 && rx_pin[g]) begin
              busy_r <= 1'b0; // false start
            end else if (bit_r >= 4'h1 && bit_r <= 4'(DATA_BITS)) begin
              sh_r <= {rx_pin[g], sh_r[7:1]}; // lsb first
            end else if (bit_r == 4'(DATA_BITS + 1)) begin
              busy_r <= 1'b0;
              stb_r  <= rx_pin[g]; // valid stop bit only, no parity
            end
          end
        end
      end
      assign rx_stb[g]  = stb_r;
      assign rx_byte[g] = sh_r;
    end
  endgenerate

  // ---------------- active port latch ----------------
  scs_port_t  port_r;
  scs_port_t  port_nxt;
  // first byte on either port wins, uart on a tie [RL10] [RL11]
  assign port_nxt = (port_r != SCS_PORT_NONE) ? port_r :
                    rx_stb[0] ? SCS_PORT_UART :
                    rx_stb[1] ? SCS_PORT_USB  : SCS_PORT_NONE;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) port_r <= SCS_PORT_NONE;
    else          port_r <= port_nxt;
  end
  assign active_port = port_r;

  // bytes from the inactive port are ignored [RL9]
  wire       b_stb  = (port_nxt == SCS_PORT_UART) ? rx_stb[0] :
                      (port_nxt == SCS_PORT_USB)  ? rx_stb[1] : 1'b0;
  wire [7:0] b_dat  = (port_nxt == SCS_PORT_USB) ? rx_byte[1] : rx_byte[0];

  // ---------------- line assembly and two slots ----------------
  logic [7:0]  lbuf_r [SLOTS][LINE_MAX];
  logic [5:0]  len_r  [SLOTS];
  logic [6:0]  wcnt_r;
  logic        skip_r;
  logic        wsel_r;
  logic        rsel_r;
  logic [1:0]  used_r;
  logic [1:0]  sent_r;
  logic [5:0]  rd_r;
  logic        out_busy_r;
  logic        err_r;
  wire         full      = (used_r == 2'(SLOTS));
  wire         eol       = b_stb && (b_dat == CHR_LF);           // [RL19]
  wire         keep      = b_stb && !eol && !skip_r && (b_dat != CHR_SEMI)
                           && (wcnt_r < 7'(LINE_MAX));            // [RL15]
  wire         commit    = eol && !full && (wcnt_r != 7'h00);
  wire         drop      = eol && full;                           // [RL20]
  wire         start_out = !out_busy_r && (used_r != sent_r);
  wire         fin_out   = out_busy_r && (rd_r == len_r[rsel_r]);
  wire         free      = exec_done && (sent_r != 2'b00);

  // capture characters; text past a separator is skipped [RL14]
  always_ff @(posedge clk) begin
    if (keep && !full) lbuf_r[wsel_r][wcnt_r[5:0]] <= b_dat;
    if (commit) len_r[wsel_r] <= 6'(wcnt_r - 7'h01);
  end

  // write side bookkeeping
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wcnt_r <= 7'h00;
      skip_r <= 1'b0;
      wsel_r <= 1'b0;
      err_r  <= 1'b0;
      err_code <= 8'h00;
    end else begin
      err_r <= drop;
      err_code <= ERR_OVERFLOW;
      if (eol) begin
        wcnt_r <= 7'h00;
        skip_r <= 1'b0;
        if (commit) wsel_r <= ~wsel_r; // [RL16]
      end else if (b_stb && b_dat == CHR_SEMI) begin
        skip_r <= 1'b1;
      end else if (keep) begin
        wcnt_r <= wcnt_r + 7'h01;
      end
    end
  end

  // slot occupancy: filled on commit, freed when executed [RL16]
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) {used_r, sent_r} <= 4'h0;
    else begin
      used_r <= used_r + {1'b0, commit} - {1'b0, free};
      sent_r <= sent_r + {1'b0, fin_out} - {1'b0, free};
    end
  end

  // stream the oldest line out to the command decoder [RL18]
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_busy_r <= 1'b0;
      rd_r       <= 6'h00;
      rsel_r     <= 1'b0;
      line_valid <= 1'b0;
      line_char  <= 8'h00;
      line_len   <= 6'h00;
    end else begin
      line_valid <= out_busy_r;
      line_char  <= lbuf_r[rsel_r][rd_r];
      line_len   <= len_r[rsel_r];
      if (start_out && !fin_out) begin
        out_busy_r <= 1'b1;
        rd_r       <= 6'h00;
      end else if (fin_out) begin
        out_busy_r <= 1'b0;
      end else if (out_busy_r) begin
        rd_r <= rd_r + 6'h01;
      end
      if (fin_out) rsel_r <= ~rsel_r; // each line streams once, in order
    end
  end
  assign err_valid = err_r;

  // ---------------- settings store, restore, preset ----------------
  typedef enum logic [2:0] {
    SCS_ST_BOOT  = 3'b000,
    SCS_ST_RD    = 3'b001,
    SCS_ST_CHK   = 3'b010,
    SCS_ST_IDLE  = 3'b011,
    SCS_ST_WR    = 3'b100
  } scs_st_t;
  scs_st_t              st_r;
  logic [3:0]           idx_r;
  logic [PAR_W-1:0]     sum_r;
  logic [NPAR*PAR_W-1:0] img_r;
  logic [PAR_W-1:0]     wsum_r;
  logic                 ok_r;
  // image words: params, mode, hours lo/hi, power-ups, checksum
  localparam logic [3:0] W_MODE = 4'(NPAR);
  localparam logic [3:0] W_HLO  = 4'(NPAR + 1);
  localparam logic [3:0] W_HHI  = 4'(NPAR + 2);
  localparam logic [3:0] W_PWR  = 4'(NPAR + 3);
  localparam logic [3:0] W_SUM  = 4'(NPAR + 4);
  logic [PAR_W-1:0] h_lo, h_hi;
  logic [HOUR_W-1:0] h_rd_r;
  logic [PWR_W-1:0]  p_rd_r;
  logic              m_rd_r;
  assign h_lo = hours[15:0];
  assign h_hi = 16'(hours[HOUR_W-1:16]);

  wire [3:0]       widx = idx_r + 4'h1;
  wire [PAR_W-1:0] wr_word =
      (widx < W_MODE) ? params[widx*PAR_W +: PAR_W] :
      (widx == W_MODE) ? {15'h0000, mode} :
      (widx == W_HLO)  ? h_lo :
      (widx == W_HHI)  ? h_hi :
      (widx == W_PWR)  ? power_ups : wsum_r + nvm_wdata;
  wire hour_tick;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= SCS_ST_BOOT;  idx_r <= 4'h0;  sum_r <= 16'h0000;
      wsum_r <= 16'h0000;   img_r <= '0;    ok_r  <= 1'b0;
      h_rd_r <= '0;  p_rd_r <= '0;  m_rd_r <= 1'b0;
      params <= '0;  mode <= continuous_attenuation_mode;
      hours <= '0;   power_ups <= '0;
      nvm_req <= 1'b0;  nvm_we <= 1'b0;  nvm_addr <= 4'h0;
      nvm_wdata <= 16'h0000;
    end else begin
      if (hour_tick) hours <= hours + 24'h000001; // [RL5]
      unique case (st_r)
        SCS_ST_BOOT: begin // power-up read of image [RL2]
          st_r <= SCS_ST_RD;  idx_r <= 4'h0;  sum_r <= 16'h0000;
          nvm_req <= 1'b1;    nvm_we <= 1'b0; nvm_addr <= 4'h0;
        end
        SCS_ST_RD: if (nvm_ack) begin
          if (idx_r < W_MODE) img_r[idx_r*PAR_W +: PAR_W] <= nvm_rdata;
          if (idx_r == W_MODE) m_rd_r <= nvm_rdata[0];
          if (idx_r == W_HLO)  h_rd_r[15:0] <= nvm_rdata;
          if (idx_r == W_HHI)  h_rd_r[HOUR_W-1:16] <= nvm_rdata[7:0];
          if (idx_r == W_PWR)  p_rd_r <= nvm_rdata;
          if (idx_r == W_SUM) begin
            ok_r <= (nvm_rdata == sum_r);
            nvm_req <= 1'b0;  st_r <= SCS_ST_CHK;
          end else begin
            sum_r <= sum_r + nvm_rdata;
            idx_r <= idx_r + 4'h1;  nvm_addr <= idx_r + 4'h1;
          end
        end
        SCS_ST_CHK: begin
          if (ok_r) begin // image good: restore all values [RL2]
            params <= img_r;  mode <= scs_mode_t'(m_rd_r);
            hours  <= h_rd_r; power_ups <= p_rd_r + 16'h0001; // [RL7]
          end else begin // bad image: factory defaults [RL3]
            params <= '0;  mode <= continuous_attenuation_mode;
            hours  <= '0;  power_ups <= 16'h0001; // [RL7]
          end
          st_r <= SCS_ST_IDLE;
        end
        SCS_ST_IDLE: begin
          if (exec_done && cmd_code == CMD_PRESET) begin // [RL4]
            params <= '0;  mode <= continuous_attenuation_mode;
          end else if (exec_done && cmd_code == CMD_STORE) begin // [RL1]
            st_r <= SCS_ST_WR;  idx_r <= 4'h0;  wsum_r <= 16'h0000;
            nvm_req <= 1'b1;  nvm_we <= 1'b1;  nvm_addr <= 4'h0;
            nvm_wdata <= params[PAR_W-1:0];
          end
        end
        SCS_ST_WR: if (nvm_ack) begin // write whole image then checksum [RL1]
          if (idx_r == W_SUM) begin
            nvm_req <= 1'b0;  nvm_we <= 1'b0;  st_r <= SCS_ST_IDLE;
          end else begin
            wsum_r    <= wsum_r + nvm_wdata;
            idx_r     <= widx;
            nvm_addr  <= widx;
            nvm_wdata <= wr_word;
          end
        end
        default: st_r <= SCS_ST_BOOT;
      endcase
    end
  end
  assign restore_ok = ok_r;

  // ---------------- hour timer, lost at power-off ----------------
  logic [27:0] sec_cnt_r;
  logic [11:0] min_cnt_r;
  wire sec_tick = (sec_cnt_r == 28'(SEC_CYC - 1));
  assign hour_tick = sec_tick && (min_cnt_r == 12'(HOUR_S - 1));
  // partial hour lives only here and is never stored [RL6]
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_cnt_r <= 28'h0000000;
      min_cnt_r <= 12'h000;
    end else begin
      sec_cnt_r <= sec_tick ? 28'h0000000 : sec_cnt_r + 28'h0000001;
      if (sec_tick) min_cnt_r <= hour_tick ? 12'h000 : min_cnt_r + 12'h001;
    end
  end

  // ---------------- version text ----------------
  logic [3:0] vidx_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vidx_r <= 4'h0; ver_char <= 8'h00; ver_last <= 1'b0;
    end else begin
      if (ver_take) vidx_r <= (vidx_r == 4'(VER_LEN-1)) ? 4'h0
                              : vidx_r + 4'h1;
      ver_char <= VER_TEXT[8*(VER_LEN-1-vidx_r) +: 8]; // [RL8]
      ver_last <= (vidx_r == 4'(VER_LEN-1));
    end
  end
endmodule

// File: core/scs_pkg.sv
// shared constants and types for the serial command settings controller
package scs_pkg;
  // serial framing: 115200 baud, 8N1, at a 200 MHz clock
  localparam int unsigned CLK_HZ        = 200000000;
  localparam int unsigned BAUD          = 115200;
  localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC      = BIT_CYC / 2;
  localparam int unsigned DATA_BITS     = 8;
  // line and queue limits
  localparam int unsigned LINE_MAX      = 64;
  localparam int unsigned SLOTS         = 2;
  localparam logic [7:0]  CHR_LF        = 8'h0A;
  localparam logic [7:0]  CHR_SEMI      = 8'h3B;
  // settings image layout
  localparam int unsigned NPAR          = 8;
  localparam int unsigned PAR_W         = 16;
  localparam int unsigned HOUR_W        = 24;
  localparam int unsigned PWR_W         = 16;
  // one hour in seconds, clock cycles per second
  localparam int unsigned HOUR_S        = 3600;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  // command codes handed on from the parser
  localparam logic [2:0]  CMD_NONE      = 3'h0;
  localparam logic [2:0]  CMD_STORE     = 3'h1;
  localparam logic [2:0]  CMD_PRESET    = 3'h2;
  localparam logic [2:0]  CMD_VERSION   = 3'h3;
  localparam logic [2:0]  CMD_OTHER     = 3'h4;
  // error code for a dropped command
  localparam logic [7:0]  ERR_OVERFLOW  = 8'h01;
  // firmware version text "R1.0 01/01/00", arbitrary values
  localparam int unsigned VER_LEN       = 13;
  localparam logic [8*VER_LEN-1:0] VER_TEXT = 104'h52312E302030312F30312F3030;
  // default operating mode
  typedef enum logic [0:0] {
    SCS_MODE_CONT  = 1'b0,
    SCS_MODE_SWEEP = 1'b1
  } scs_mode_t;
  localparam scs_mode_t continuous_attenuation_mode = SCS_MODE_CONT;
  // active port
  typedef enum logic [1:0] {
    SCS_PORT_NONE = 2'b00,
    SCS_PORT_UART = 2'b01,
    SCS_PORT_USB  = 2'b10
  } scs_port_t;
endpackage

// File: test/scs_ctrl_assertions.sv
// port checks for the settings controller
`timescale 1ns/1ps
module scs_ctrl_assertions
  import scs_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [2:0]             cmd_code,
  input wire logic                   exec_done,
  input wire logic                   nvm_ack,
  input wire logic                   line_valid,
  input wire logic [5:0]             line_len,
  input wire logic                   nvm_req,
  input wire logic                   nvm_we,
  input wire logic [3:0]             nvm_addr,
  input wire logic [PAR_W-1:0]       nvm_wdata,
  input wire logic [NPAR*PAR_W-1:0]  params,
  input wire scs_pkg::scs_mode_t     mode,
  input wire scs_pkg::scs_port_t     active_port,
  input wire logic [7:0]             ver_char,
  input wire logic                   ver_last,
  input wire logic                   err_valid,
  input wire logic [7:0]             err_code
);
  import scs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles the current line burst has lasted
  logic [6:0] run_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_r <= '0;
    else run_r <= line_valid ? run_r + 7'h01 : 7'h00;
  end
  property p_hold; nvm_req && !nvm_ack |=> nvm_req &&
    $stable({nvm_we, nvm_addr, nvm_wdata}); endproperty
  a_hold: assert property (p_hold) else $error("nvm request moved");
  property p_boot; $rose(reset_n) |-> ##[0:16]
    (nvm_req && !nvm_we && nvm_addr == 4'h0); endproperty
  a_boot: assert property (p_boot) else $error("no boot read");
  property p_run; $fell(line_valid) |->
    run_r == {1'b0, $past(line_len)} + 7'h01; endproperty
  a_run: assert property (p_run) else $error("line burst length");
  property p_latch; active_port != SCS_PORT_NONE |=> $stable(active_port);
  endproperty
  a_latch: assert property (p_latch) else $error("port changed");
  property p_err; err_valid |-> err_code == ERR_OVERFLOW ##1 !err_valid;
  endproperty
  a_err: assert property (p_err) else $error("bad error pulse");
  property p_preset; exec_done && cmd_code == CMD_PRESET |-> ##[1:4]
    (mode == SCS_MODE_CONT && params == '0); endproperty
  a_preset: assert property (p_preset) else $error("preset missed");
  property p_store; exec_done && cmd_code == CMD_STORE |-> ##[1:8]
    (nvm_req && nvm_we); endproperty
  a_store: assert property (p_store) else $error("store missed");
  property p_ver; ver_last |-> ver_char == VER_TEXT[7:0]; endproperty
  a_ver: assert property (p_ver) else $error("last version char");
  c_err: cover property (err_valid);
  c_store: cover property (exec_done && cmd_code == CMD_STORE);
  c_line: cover property ($fell(line_valid));
endmodule
bind scs_ctrl scs_ctrl_assertions u_chk (
  .clk, .reset_n, .cmd_code, .exec_done, .nvm_ack, .line_valid,
  .line_len, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata, .params, .mode,
  .active_port, .ver_char, .ver_last, .err_valid, .err_code
);

// File: test/scs_host_model.sv
// host side serial sender, 8N1 frames on one line
`timescale 1ns/1ps
module scs_host_model (
  input  wire logic clk,
  output logic      tx
);
  import scs_pkg::*;
  initial tx = 1'b1; // line idles high between frames
  // start bit, eight data bits lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  // one-char line closed by line feed, far below the line limit
  task automatic send_line(input logic [7:0] c);
    send_byte(c);
    send_byte(CHR_LF);
  endtask
endmodule

// File: test/test_scs_ctrl.sv
// self-checking bench for the settings controller
`timescale 1ns/1ps
module test_scs_ctrl;
  import scs_pkg::*;
  localparam int CYC_MAX = 100000; // five frames plus boots and slack
  logic clk, reset_n, exec_done, nvm_ack, ver_take, lv_q;
  logic [2:0] cmd_code;
  logic [PAR_W-1:0] nvm_rdata;
  wire uart_rx, usb_rx, line_valid, nvm_req, nvm_we, ver_last;
  wire err_valid, restore_ok;
  wire [7:0] line_char, ver_char, err_code;
  wire [5:0] line_len;
  wire [3:0] nvm_addr;
  wire [PAR_W-1:0] nvm_wdata;
  wire [NPAR*PAR_W-1:0] params;
  wire [HOUR_W-1:0] hours;
  wire [PWR_W-1:0] power_ups;
  scs_mode_t mode;
  scs_port_t active_port;
  logic [PAR_W-1:0] img [0:12];
  logic [7:0] ln_char [0:3];
  int fails, cmp_count, cyc, rd_cnt, wr_cnt, n_lines, n_err;
  scs_ctrl u_dut (.clk(clk), .reset_n(reset_n), .uart_rx(uart_rx),
    .usb_rx(usb_rx), .cmd_code(cmd_code), .exec_done(exec_done),
    .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .ver_take(ver_take),
    .line_valid(line_valid), .line_char(line_char), .line_len(line_len),
    .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .params(params), .mode(mode),
    .active_port(active_port), .hours(hours), .power_ups(power_ups),
    .ver_char(ver_char), .ver_last(ver_last), .err_valid(err_valid),
    .err_code(err_code), .restore_ok(restore_ok));
  scs_host_model u_uart (.clk(clk), .tx(uart_rx));
  scs_host_model u_usb (.clk(clk), .tx(usb_rx));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // memory answers each request once, data scrambled outside the ack
  always @(posedge clk) begin
    cyc++;
    nvm_ack <= nvm_req && !nvm_ack;
    nvm_rdata <= (nvm_req && !nvm_ack) ? img[nvm_addr] : ~img[nvm_addr];
    if (nvm_req && !nvm_ack && nvm_we) img[nvm_addr] <= nvm_wdata;
    if (nvm_req && !nvm_ack) wr_cnt += nvm_we;
    if (nvm_req && !nvm_ack) rd_cnt += !nvm_we;
    lv_q <= line_valid;
    if (line_valid && !lv_q && n_lines < 4) ln_char[n_lines] = line_char;
    if (line_valid && !lv_q) n_lines++;
    if (err_valid) n_err++;
    if (cyc == CYC_MAX) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [127:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // settings image, checksum optionally spoiled
  task automatic load_img(input logic bad);
    img[12] = '0;
    for (int i = 0; i < 12; i++) begin
      img[i] = (i < 8) ? 16'(32'h1111 * (i + 1)) : 16'h0000;
    end
    img[8] = 16'h0001;
    img[9] = 16'h0005;
    img[11] = 16'h0009;
    for (int i = 0; i < 12; i++) img[12] += img[i];
    if (bad) img[12] = ~img[12];
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    rd_cnt = 0;
    reset_n <= 1'b1;
    for (int i = 0; i < 2000 && rd_cnt < 13; i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic pulse_exec(input logic [2:0] c);
    cmd_code <= c;
    exec_done <= 1'b1;
    @(posedge clk);
    exec_done <= 1'b0;
  endtask
  task automatic t_restore(input logic [PWR_W-1:0] pw);
    for (int i = 0; i < 8; i++) chk("param", img[i], params[16*i +: 16]);
    chk("mode", img[8][0], mode);
    chk("hours", {img[10][7:0], img[9]}, hours);
    chk("power_ups", pw, power_ups);
    chk("restore_ok", 1'b1, restore_ok);
    chk("port", SCS_PORT_NONE, active_port);
  endtask
  // usb speaks first, uart traffic overlaps, third line overflows
  task automatic t_lines;
    fork
      begin
        u_usb.send_line(8'h41);
        u_usb.send_line(8'h42);
        u_usb.send_byte(CHR_LF);
      end
      begin
        repeat (300) @(posedge clk);
        u_uart.send_line(8'h58);
      end
    join
    repeat (40) @(posedge clk);
    chk("port", SCS_PORT_USB, active_port);
    chk("lines", 2, n_lines);
    chk("line0", 8'h41, ln_char[0]);
    chk("line1", 8'h42, ln_char[1]);
    chk("errors", 1, n_err);
  endtask
  task automatic t_store;
    logic [PAR_W-1:0] s;
    wr_cnt = 0;
    pulse_exec(CMD_STORE);
    for (int i = 0; i < 2000 && wr_cnt < 13; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    s = '0;
    for (int i = 0; i < 12; i++) s += img[i];
    for (int i = 0; i < 8; i++) chk("img", 16'(32'h1111 * (i + 1)), img[i]);
    chk("img_mode", 16'h0001, img[8]);
    chk("img_pwr", 16'h000A, img[11]);
    chk("img_sum", s, img[12]);
  endtask
  task automatic t_preset;
    pulse_exec(CMD_PRESET);
    repeat (8) @(posedge clk);
    chk("params", '0, params);
    chk("mode", SCS_MODE_CONT, mode);
  endtask
  task automatic t_version;
    for (int i = VER_LEN - 1; i >= 0; i--) begin
      chk("ver_char", VER_TEXT[8*i +: 8], ver_char);
      chk("ver_last", i == 0, ver_last);
      ver_take <= 1'b1;
      @(posedge clk);
      ver_take <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic t_bad;
    load_img(1'b1);
    do_reset;
    chk("params", '0, params);
    chk("mode", SCS_MODE_CONT, mode);
    chk("restore_ok", 1'b0, restore_ok);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {reset_n, exec_done, ver_take, nvm_ack, lv_q} = '0;
    {cmd_code, nvm_rdata} = '0;
    {fails, cmp_count, cyc, rd_cnt, wr_cnt, n_lines, n_err} = '0;
    load_img(1'b0);
    @(posedge clk);
    do_reset;
    t_restore(16'h000A);
    t_lines;
    t_store;
    t_preset;
    t_version;
    do_reset;
    t_restore(16'h000B);
    t_bad;
    report_and_stop();
  end
endmodule
